// [crs_pkg.sv]
// Constants, states and carrier types for the core register, stack and map block
package crs_pkg;

  // Software register offsets on the plain register port
  localparam logic [7:0] OFF_ACC     = 8'h00;
  localparam logic [7:0] OFF_IDX_X   = 8'h01;
  localparam logic [7:0] OFF_IDX_Y   = 8'h02;
  localparam logic [7:0] OFF_SP      = 8'h03;
  localparam logic [7:0] OFF_PC_LO   = 8'h04;
  localparam logic [7:0] OFF_PC_HI   = 8'h05;
  localparam logic [7:0] OFF_FLAGS   = 8'h06;
  localparam logic [7:0] OFF_CMD     = 8'h07;
  localparam logic [7:0] OFF_MADDR_L = 8'h08;
  localparam logic [7:0] OFF_MADDR_H = 8'h09;
  localparam logic [7:0] OFF_MDATA   = 8'h0A;
  localparam logic [7:0] OFF_REGION  = 8'h0B;
  localparam logic [7:0] OFF_EAX_L   = 8'h0C;
  localparam logic [7:0] OFF_EAX_H   = 8'h0D;
  localparam logic [7:0] OFF_EAY_L   = 8'h0E;
  localparam logic [7:0] OFF_EAY_H   = 8'h0F;
  localparam logic [7:0] OFF_STATUS  = 8'h10;

  // Address map boundaries
  localparam logic [15:0] ROM_BASE  = 16'h2000;
  localparam logic [15:0] ROM_TOP   = 16'h3FFF;
  localparam logic [15:0] SPC_BASE  = 16'h3F00;
  localparam logic [15:0] VEC_BASE  = 16'h3FF4;
  localparam logic [15:0] ZP_TOP    = 16'h00FF;
  localparam logic [15:0] RAM0_TOP  = 16'h007F;
  localparam logic [15:0] RAM1_BASE = 16'h0100;
  localparam logic [15:0] RAM1_TOP  = 16'h027F;
  localparam logic [15:0] RESET_VEC = 16'h3FFE;
  localparam logic [7:0]  SPC_PAGE  = 8'h3F;
  localparam logic [7:0]  STACK_PG  = 8'h01;
  localparam logic [8:0]  RAM1_IDX  = 9'h080;
  localparam int          RAM_DEPTH = 512;

  // Region bits of the decode result
  localparam int RG_ROM = 0;
  localparam int RG_SPC = 1;
  localparam int RG_VEC = 2;
  localparam int RG_ZP  = 3;
  localparam int RG_RAM = 4;

  // Flag bit positions
  localparam int FL_C = 0;
  localparam int FL_Z = 1;
  localparam int FL_I = 2;
  localparam int FL_D = 3;
  localparam int FL_B = 4;
  localparam int FL_T = 5;
  localparam int FL_V = 6;
  localparam int FL_N = 7;
  localparam logic [7:0] FLAGS_RST = 8'h04;

  // Command codes, low nibble of a command write; source in bits 6:4
  localparam logic [3:0] CMD_PUSH_ACC   = 4'h1;
  localparam logic [3:0] CMD_POP_ACC    = 4'h2;
  localparam logic [3:0] CMD_PUSH_FLAGS = 4'h3;
  localparam logic [3:0] CMD_POP_FLAGS  = 4'h4;
  localparam logic [3:0] CMD_CALL       = 4'h5;
  localparam logic [3:0] CMD_CALL_SPC   = 4'h6;
  localparam logic [3:0] CMD_RET_SUB    = 4'h7;
  localparam logic [3:0] CMD_IRQ        = 4'h8;
  localparam logic [3:0] CMD_RET_IRQ    = 4'h9;
  localparam logic [3:0] CMD_COPY_X_SP  = 4'hA;
  localparam int         CMD_SRC_LSB    = 4;
  localparam logic [2:0] SRC_RESET      = 3'h0;
  localparam logic [2:0] SRC_LAST       = 3'h5;
  localparam int         ST_BUSY        = 0;

  // Sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_PUSH = 3'b001,
    ST_POP  = 3'b010,
    ST_VEC1 = 3'b011,
    ST_VEC2 = 3'b100,
    ST_VEC3 = 3'b101
  } crs_state_e;

  // Register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } crs_bus_s;

endpackage : crs_pkg

// [crs_core_regs.sv]
// Core registers, stack sequencer and address decoder of the 8-bit core
//
// Functional notes
// - ROM decoded at 2000h through 3FFFh
// - Special page 3F00h-3FFFh reachable by short call
// - Vectors fetched from 3FF4h through 3FFFh
// - Zero page is 0000h through 00FFh
// - RAM at 0000h-007Fh and 0100h-027Fh
// - RAM holds data and the stack
// - Eight-bit accumulator as main operand register
// - X-indexed address is operand plus X
// - Index-memory flag makes X the address
// - Y-indexed address is operand plus Y
// - Stack pointer names next free location
// - Stack pointer not reset; copy from X
// - Interrupt pushes upper PC, lower PC, flags
// - Interrupt return pops flags then PC
// - Accumulator saved only by explicit push
// - Flags pushed and popped by own commands
// - Call saves only the program counter
// - PC is lower byte plus 6-bit upper
// - Flag register updated; branch flags readable
// - Stack depth allows 64 nesting levels
// - Interrupt sets disable flag, loads vector, acks
//
// The address map and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module crs_core_regs
  import crs_pkg::*;
(
  input  wire logic        clk_i,      // 10 MHz system clock
  input  wire logic        rst_i,      // Synchronous reset, active high
  input  wire crs_bus_s    bus_i,      // Register port request
  input  wire logic [7:0]  rom_data_i, // Program memory data, one cycle after read
  output logic      [7:0]  rdata_o,    // Read data, cycle after read strobe
  output logic             busy_o,     // Sequencer working
  output logic      [15:0] rom_addr_o, // Vector fetch address
  output logic             rom_rd_o,   // Vector fetch read strobe
  output logic             irq_ack_o,  // Request-bit clear pulse
  output logic      [2:0]  irq_src_o   // Source whose request is cleared
);

  // Region decode of a 16-bit address
  function automatic logic [4:0] crs_region(input logic [15:0] a);
    logic [4:0] r;
    r         = 5'h00;
    r[RG_ROM] = (a >= ROM_BASE) && (a <= ROM_TOP);
    r[RG_SPC] = (a >= SPC_BASE) && (a <= ROM_TOP);
    r[RG_VEC] = (a >= VEC_BASE) && (a <= ROM_TOP);
    r[RG_ZP]  = (a <= ZP_TOP);
    r[RG_RAM] = (a <= RAM0_TOP) || ((a >= RAM1_BASE) && (a <= RAM1_TOP));
    return r;
  endfunction : crs_region

  // Folds both RAM windows into one 512-entry index
  function automatic logic [8:0] crs_ram_idx(input logic [15:0] a);
    logic [15:0] d;
    d = a - RAM1_BASE;
    if (a <= RAM0_TOP)
      return a[8:0];
    return d[8:0] + RAM1_IDX;
  endfunction : crs_ram_idx

  // Programmer-visible registers
  logic [7:0]  acc_r;        // Accumulator
  logic [7:0]  x_r;          // Index X
  logic [7:0]  y_r;          // Index Y
  logic [7:0]  sp_r;         // Stack pointer, no reset; 256 bytes cover 64 levels
  logic [7:0]  pcl_r;        // program_counter_lower
  logic [5:0]  pch_r;        // program_counter_upper, only 6 bits exist
  logic [7:0]  flags_r;      // processor_flags
  logic [15:0] maddr_r;      // Memory window / operand address
  logic [7:0]  ram_r [RAM_DEPTH]; // Internal RAM, data and stack

  // Sequencer state
  crs_state_e  state_r;      // Current step
  logic [3:0]  op_r;         // Command in progress
  logic [1:0]  cnt_r;        // Bytes left to push or pop
  logic [15:0] tgt_r;        // Call target
  logic [15:0] vec_r;        // Low byte address of the vector
  logic [2:0]  src_r;        // Interrupt source number
  logic [7:0]  rdata_r;      // Registered read data
  logic [15:0] rom_addr_r;   // Vector fetch address
  logic        rom_rd_r;     // Vector fetch strobe
  logic        ack_r;        // Request clear pulse

  // Decode of register port
  wire         wr_w     = bus_i.wr;
  wire         rd_w     = bus_i.rd;
  wire [7:0]   wd_w     = bus_i.wdata;
  wire         idle_w   = (state_r == ST_IDLE);
  wire [3:0]   cop_w    = wd_w[3:0];
  wire [2:0]   csrc_w   = wd_w[CMD_SRC_LSB +: 3];
  wire         cmd_wr_w = wr_w && (bus_i.addr == OFF_CMD) && idle_w;
  // Ordinary writes are ignored while a sequence runs, so it cannot be torn
  wire         reg_wr_w = wr_w && idle_w;

  // Command acceptance; masked sources refused while disable flag is set
  wire irq_ok_w  = (csrc_w <= SRC_LAST) &&
                   ((csrc_w == SRC_RESET) || !flags_r[FL_I]);
  wire go_push_w = cmd_wr_w && ((cop_w == CMD_PUSH_ACC) || (cop_w == CMD_PUSH_FLAGS) ||
                   (cop_w == CMD_CALL) || (cop_w == CMD_CALL_SPC) ||
                   ((cop_w == CMD_IRQ) && irq_ok_w));
  wire go_pop_w  = cmd_wr_w && ((cop_w == CMD_POP_ACC) || (cop_w == CMD_POP_FLAGS) ||
                   (cop_w == CMD_RET_SUB) || (cop_w == CMD_RET_IRQ));
  wire go_txs_w  = cmd_wr_w && (cop_w == CMD_COPY_X_SP);

  // Byte counts per command
  wire [1:0] push_n_w = (cop_w == CMD_IRQ) ? 2'd3 :
                        ((cop_w == CMD_CALL) || (cop_w == CMD_CALL_SPC)) ? 2'd2 : 2'd1;
  wire [1:0] pop_n_w  = (cop_w == CMD_RET_IRQ) ? 2'd3 :
                        (cop_w == CMD_RET_SUB) ? 2'd2 : 2'd1;

  // Call target; special-page form supplies only the low byte
  wire [15:0] tgt_w = (cop_w == CMD_CALL_SPC) ? {SPC_PAGE, maddr_r[7:0]} : maddr_r;

  // Vector low address for a source: top of ROM stepping down by two
  wire [3:0]  src2_w    = {csrc_w, 1'b0};
  wire [15:0] vec_w     = RESET_VEC - {12'h000, src2_w};

  // Push side: byte order upper PC, lower PC, then flags
  wire        push_we_w = (state_r == ST_PUSH);
  logic [7:0] push_byte_w;
  always_comb
  begin
    // Select byte by command and bytes remaining
    push_byte_w = acc_r;
    if (op_r == CMD_PUSH_FLAGS)
      push_byte_w = flags_r;
    else if (op_r == CMD_IRQ)
      push_byte_w = (cnt_r == 2'd3) ? {2'b00, pch_r} :
                    (cnt_r == 2'd2) ? pcl_r : flags_r;
    else if ((op_r == CMD_CALL) || (op_r == CMD_CALL_SPC))
      push_byte_w = (cnt_r == 2'd2) ? {2'b00, pch_r} : pcl_r;
  end

  // Pop side: pre-increment, read the new top of stack
  wire        pop_re_w  = (state_r == ST_POP);
  wire [7:0]  sp_inc_w  = sp_r + 8'h01;
  wire [7:0]  sp_dec_w  = sp_r - 8'h01;
  wire [8:0]  pop_idx_w = crs_ram_idx({STACK_PG, sp_inc_w});
  wire [8:0]  psh_idx_w = crs_ram_idx({STACK_PG, sp_r});
  wire [7:0]  pop_byte_w = ram_r[pop_idx_w];
  // Destination of a popped byte: flags first, then lower, then upper PC
  wire pop_flags_w = pop_re_w && ((op_r == CMD_POP_FLAGS) ||
                     ((op_r == CMD_RET_IRQ) && (cnt_r == 2'd3)));
  wire pop_pcl_w   = pop_re_w && (((op_r == CMD_RET_IRQ) && (cnt_r == 2'd2)) ||
                     ((op_r == CMD_RET_SUB) && (cnt_r == 2'd2)));
  wire pop_pch_w   = pop_re_w && (op_r != CMD_POP_ACC) && (op_r != CMD_POP_FLAGS) &&
                     (cnt_r == 2'd1);
  wire pop_acc_w   = pop_re_w && (op_r == CMD_POP_ACC);

  // RAM write port; stack push wins, window writes only when idle
  wire [4:0]  mreg_w    = crs_region(maddr_r);
  wire        mwin_we_w = reg_wr_w && (bus_i.addr == OFF_MDATA) && mreg_w[RG_RAM];
  wire        ram_we_w  = push_we_w || mwin_we_w;
  wire [8:0]  ram_idx_w = push_we_w ? psh_idx_w : crs_ram_idx(maddr_r);
  wire [7:0]  ram_wd_w  = push_we_w ? push_byte_w : wd_w;

  // Effective addresses
  wire [15:0] x16_w  = {8'h00, x_r};
  wire [15:0] eax_w  = flags_r[FL_T] ? x16_w : (maddr_r + x16_w);
  wire [15:0] eay_w  = maddr_r + {8'h00, y_r};
  wire        last_w = (cnt_r == 2'd1);

  // RAM storage, no reset so contents survive a reset
  always_ff @(posedge clk_i)
  begin
    if (ram_we_w)
      ram_r[ram_idx_w] <= ram_wd_w;
  end

  // Stack pointer: copy from X, post-decrement on push, pre-increment on pop
  always_ff @(posedge clk_i)
  begin
    if (go_txs_w)
      sp_r <= x_r;
    else if (push_we_w)
      sp_r <= sp_dec_w;
    else if (pop_re_w)
      sp_r <= sp_inc_w;
  end

  // Accumulator and index registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      acc_r <= 8'h00;
      x_r   <= 8'h00;
      y_r   <= 8'h00;
    end
    else
    begin
      // Popped value or software load
      if (pop_acc_w)
        acc_r <= pop_byte_w;
      else if (reg_wr_w && (bus_i.addr == OFF_ACC))
        acc_r <= wd_w;
      if (reg_wr_w && (bus_i.addr == OFF_IDX_X))
        x_r <= wd_w;
      if (reg_wr_w && (bus_i.addr == OFF_IDX_Y))
        y_r <= wd_w;
    end
  end

  // Flag register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      flags_r <= FLAGS_RST;
    else if (pop_flags_w)
      flags_r <= pop_byte_w;
    else if (pop_acc_w)
    begin
      // Popping into the accumulator updates sign and zero
      flags_r[FL_N] <= pop_byte_w[7];
      flags_r[FL_Z] <= (pop_byte_w == 8'h00);
    end
    else if (push_we_w && (op_r == CMD_IRQ) && last_w)
      flags_r[FL_I] <= 1'b1;
    else if (reg_wr_w && (bus_i.addr == OFF_FLAGS))
      flags_r <= wd_w;
  end

  // Program counter: split lower and 6-bit upper byte
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pcl_r <= 8'h00;
      pch_r <= 6'h00;
    end
    else if (push_we_w && last_w && ((op_r == CMD_CALL) || (op_r == CMD_CALL_SPC)))
    begin
      pcl_r <= tgt_r[7:0];
      pch_r <= tgt_r[13:8];
    end
    else if (state_r == ST_VEC2)
      pcl_r <= rom_data_i;
    else if (state_r == ST_VEC3)
      pch_r <= rom_data_i[5:0];
    else if (pop_pcl_w)
      pcl_r <= pop_byte_w;
    else if (pop_pch_w)
      pch_r <= pop_byte_w[5:0];
    else if (reg_wr_w && (bus_i.addr == OFF_PC_LO))
      pcl_r <= wd_w;
    else if (reg_wr_w && (bus_i.addr == OFF_PC_HI))
      pch_r <= wd_w[5:0];
  end

  // Memory window address
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      maddr_r <= 16'h0000;
    else if (reg_wr_w && (bus_i.addr == OFF_MADDR_L))
      maddr_r[7:0] <= wd_w;
    else if (reg_wr_w && (bus_i.addr == OFF_MADDR_H))
      maddr_r[15:8] <= wd_w;
  end

  // Sequencer; reset starts with the reset vector fetch
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_r    <= ST_VEC1;
      op_r       <= 4'h0;
      cnt_r      <= 2'd0;
      tgt_r      <= 16'h0000;
      src_r      <= SRC_RESET;
      vec_r      <= RESET_VEC;
      rom_addr_r <= RESET_VEC;
      rom_rd_r   <= 1'b1;
      ack_r      <= 1'b0;
    end
    else
    begin
      ack_r <= 1'b0;
      case (state_r)
        ST_IDLE:
        begin
          // Latch command, byte count and targets
          op_r  <= cop_w;
          src_r <= csrc_w;
          vec_r <= vec_w;
          tgt_r <= tgt_w;
          if (go_push_w)
          begin
            cnt_r   <= push_n_w;
            state_r <= ST_PUSH;
          end
          else if (go_pop_w)
          begin
            cnt_r   <= pop_n_w;
            state_r <= ST_POP;
          end
        end
        ST_PUSH:
        begin
          // One byte per cycle; interrupt then fetches its vector
          cnt_r <= cnt_r - 2'd1;
          if (last_w)
          begin
            if (op_r == CMD_IRQ)
            begin
              state_r    <= ST_VEC1;
              rom_addr_r <= vec_r;
              rom_rd_r   <= 1'b1;
              ack_r      <= 1'b1;
            end
            else
              state_r <= ST_IDLE;
          end
        end
        ST_POP:
        begin
          // One byte per cycle
          cnt_r <= cnt_r - 2'd1;
          if (last_w)
            state_r <= ST_IDLE;
        end
        ST_VEC1:
        begin
          // Second byte of the vector
          rom_addr_r <= vec_r + 16'h0001;
          state_r    <= ST_VEC2;
        end
        ST_VEC2:
        begin
          rom_rd_r <= 1'b0;
          state_r  <= ST_VEC3;
        end
        ST_VEC3:
          state_r <= ST_IDLE;
        default:
          state_r <= ST_IDLE;
      endcase
    end
  end

  // Read mux
  logic [7:0] rmux_w;
  always_comb
  begin
    // Unmapped offsets read as zero
    case (bus_i.addr)
      OFF_ACC:     rmux_w = acc_r;
      OFF_IDX_X:   rmux_w = x_r;
      OFF_IDX_Y:   rmux_w = y_r;
      OFF_SP:      rmux_w = sp_r;
      OFF_PC_LO:   rmux_w = pcl_r;
      OFF_PC_HI:   rmux_w = {2'b00, pch_r};
      OFF_FLAGS:   rmux_w = flags_r;
      OFF_MADDR_L: rmux_w = maddr_r[7:0];
      OFF_MADDR_H: rmux_w = maddr_r[15:8];
      OFF_MDATA:   rmux_w = mreg_w[RG_RAM] ? ram_r[crs_ram_idx(maddr_r)] : 8'h00;
      OFF_REGION:  rmux_w = {3'b000, mreg_w};
      OFF_EAX_L:   rmux_w = eax_w[7:0];
      OFF_EAX_H:   rmux_w = eax_w[15:8];
      OFF_EAY_L:   rmux_w = eay_w[7:0];
      OFF_EAY_H:   rmux_w = eay_w[15:8];
      OFF_STATUS:  rmux_w = {7'h00, !idle_w};
      default:     rmux_w = 8'h00;
    endcase
  end

  // Read data stands one cycle only
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      rdata_r <= 8'h00;
    else
      rdata_r <= rd_w ? rmux_w : 8'h00;
  end

  // Outputs straight from flops, except busy decoded from the state
  assign rdata_o    = rdata_r;
  assign busy_o     = (state_r != ST_IDLE);
  assign rom_addr_o = rom_addr_r;
  assign rom_rd_o   = rom_rd_r;
  assign irq_ack_o  = ack_r;
  assign irq_src_o  = src_r;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Interrupt entry and return steps
  wire irq_go_w = go_push_w && (cop_w == CMD_IRQ);
  wire rti_go_w = go_pop_w && (cop_w == CMD_RET_IRQ);
  wire jsr_go_w = go_push_w && (cop_w == CMD_CALL);
  sequence s_irq_push;
    (push_we_w && push_byte_w == {2'b00, pch_r}) ##1
    (push_we_w && push_byte_w == pcl_r) ##1 (push_we_w && push_byte_w == flags_r);
  endsequence
  sequence s_rti_pop;
    pop_flags_w ##1 pop_pcl_w ##1 (pop_pch_w && !pop_pcl_w);
  endsequence

  a_irq_push_order: assert property (irq_go_w |=> s_irq_push)
    else $error("interrupt push order wrong");
  a_rti_pop_order: assert property (rti_go_w |=> s_rti_pop)
    else $error("interrupt return pop order wrong");
  a_irq_sets_disable: assert property (irq_go_w |-> ##4 (flags_r[FL_I] && irq_ack_o))
    else $error("interrupt did not set disable flag and ack");
  a_irq_vector_addr: assert property (
    irq_go_w |-> ##4 (rom_rd_o && rom_addr_o == $past(vec_w, 4)))
    else $error("vector fetch address wrong");
  a_sp_push_dec: assert property (push_we_w |=> sp_r == $past(sp_r) - 8'h01)
    else $error("stack pointer not decremented after push");
  a_sp_pop_inc: assert property (pop_re_w |=> sp_r == $past(sp_r) + 8'h01)
    else $error("stack pointer not incremented on pop");
  a_call_pc_only: assert property (
    jsr_go_w |-> ##3 (idle_w && pcl_r == $past(maddr_r[7:0], 3)))
    else $error("call did not finish after two pushes");
  a_ea_index_mode: assert property (
    rd_w && bus_i.addr == OFF_EAX_L && flags_r[FL_T] |=> rdata_o == $past(x_r))
    else $error("index mode address is not X");
  a_rom_decode: assert property (
    rd_w && bus_i.addr == OFF_REGION |=>
    rdata_o[RG_ROM] == ($past(maddr_r) >= ROM_BASE && $past(maddr_r) <= ROM_TOP))
    else $error("ROM region decode wrong");
  a_txs_loads_sp: assert property (go_txs_w |=> sp_r == $past(x_r))
    else $error("stack pointer not copied from X");

endmodule : crs_core_regs

`default_nettype wire

// [crs_core_regs_bench.sv]
// Self-checking bench for the core register, stack and address map block
`timescale 1ns/1ps
`default_nettype none

module crs_core_regs_bench
  import crs_pkg::*;
;
  logic        clk_i = 1'b0; // 100 ns system clock
  logic        rst_i;        // Synchronous reset
  crs_bus_s    bus;          // Register port request
  logic [7:0]  rom_q;        // Program memory answer
  logic [7:0]  rdata;        // Read data
  logic        busy;         // Sequencer busy
  logic [15:0] rom_addr;     // Vector fetch address
  logic        rom_rd;       // Vector fetch strobe
  logic        ack;          // Request clear pulse
  logic [2:0]  src;          // Source of clear pulse
  logic [2:0]  ack_src;      // Last source seen with a pulse
  logic [7:0]  v;            // Scratch read value
  int          error_cnt = 0;
  int          checks = 0;
  int          ack_cnt = 0;
  // Region probe table: address and expected {ram,zp,vec,spc,rom}
  logic [15:0] ra [14] = '{16'h0000, 16'h007F, 16'h0080, 16'h00FF, 16'h0100, 16'h027F,
    16'h0280, 16'h1FFF, 16'h2000, 16'h3EFF, 16'h3F00, 16'h3FF3, 16'h3FF4, 16'h3FFF};
  logic [4:0]  re [14] = '{5'h18, 5'h18, 5'h08, 5'h08, 5'h10, 5'h10, 5'h00, 5'h00,
    5'h01, 5'h01, 5'h03, 5'h03, 5'h07, 5'h07};

  crs_core_regs DUT (.clk_i(clk_i), .rst_i(rst_i), .bus_i(bus), .rom_data_i(rom_q),
    .rdata_o(rdata), .busy_o(busy), .rom_addr_o(rom_addr), .rom_rd_o(rom_rd),
    .irq_ack_o(ack), .irq_src_o(src));

  // Free-running clock
  initial forever #50 clk_i = ~clk_i;

  // Program memory: low address byte xor A5, one cycle late
  always @(posedge clk_i) rom_q <= rom_addr[7:0] ^ 8'hA5;

  // Count clear pulses; a stuck pulse shows as a wrong count
  always @(posedge clk_i)
  begin
    if (ack === 1'b1)
    begin
      ack_cnt <= ack_cnt + 1;
      ack_src <= src;
    end
  end

  // Compare and count
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // One-cycle write; an idle edge follows so strobes never merge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i) bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clk_i) bus <= '0;
  endtask : wr

  // One-cycle read; data sampled just after the answering edge
  task automatic rchk(input string nm, input logic [7:0] a, input logic [15:0] e);
    @(posedge clk_i) bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk_i) bus <= '0;
    #1 v = rdata;
    chk(nm, {8'h00, v}, e);
  endtask : rchk

  // Command write, then bounded wait for the sequencer
  task automatic cmd(input logic [7:0] c);
    int n;
    wr(OFF_CMD, c);
    #1;
    for (n = 0; n < 40 && busy !== 1'b0; n++) @(posedge clk_i) #1;
    chk("busy", {15'h0, busy}, 16'h0);
  endtask : cmd

  // Set the 16-bit window address
  task automatic win(input logic [15:0] a);
    wr(OFF_MADDR_L, a[7:0]);
    wr(OFF_MADDR_H, a[15:8]);
  endtask : win

  // Load and check the program counter
  task automatic pc(input logic [15:0] a);
    wr(OFF_PC_LO, a[7:0]);
    wr(OFF_PC_HI, a[15:8]);
  endtask : pc

  task automatic rpc(input logic [15:0] e);
    rchk("pc_lo", OFF_PC_LO, {8'h00, e[7:0]});
    rchk("pc_hi", OFF_PC_HI, {8'h00, e[15:8]});
  endtask : rpc

  // Check one RAM byte through the window
  task automatic rmem(input logic [15:0] a, input logic [7:0] e);
    win(a);
    rchk("mem", OFF_MDATA, {8'h00, e});
  endtask : rmem

  // Verdict, shared by the main sequence and the watchdog
  task automatic tally_and_finish();
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : tally_and_finish

  // Watchdog well beyond the expected run of under a thousand cycles
  initial
  begin
    #1000000;
    error_cnt++;
    tally_and_finish();
  end

  // Main sequence
  initial
  begin
    rst_i = 1'b1;
    bus = '0;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i); // Reset vector fetch takes three cycles
    rpc(16'h1A5B);
    chk("rom_addr", rom_addr, 16'h3FFF);
    chk("rom_rd", {15'h0, rom_rd}, 16'h0000);
    rchk("flags", OFF_FLAGS, 16'h0004);
    rchk("acc", OFF_ACC, 16'h0000);
    wr(OFF_ACC, 8'h3C);
    wr(OFF_IDX_X, 8'hF0);
    wr(OFF_IDX_Y, 8'h81);
    wr(OFF_PC_HI, 8'hFF);
    wr(OFF_SP, 8'h11);
    rchk("acc", OFF_ACC, 16'h003C);
    rchk("pc_hi", OFF_PC_HI, 16'h003F);
    // Indexed addresses; both the X sum and the Y sum carry into the high byte
    win(16'h0290);
    rchk("eax_l", OFF_EAX_L, 16'h0080);
    rchk("eax_h", OFF_EAX_H, 16'h0003);
    rchk("eay_l", OFF_EAY_L, 16'h0011);
    rchk("eay_h", OFF_EAY_H, 16'h0003);
    wr(OFF_FLAGS, 8'h24);
    rchk("eax_t", OFF_EAX_L, 16'h00F0);
    rchk("eax_th", OFF_EAX_H, 16'h0000);
    wr(OFF_FLAGS, 8'h04);
    // Region decode at every boundary
    foreach (ra[i])
    begin
      win(ra[i]);
      rchk("region", OFF_REGION, {11'h0, re[i]});
    end
    // Stack pointer only through the copy command
    cmd({4'h0, CMD_COPY_X_SP});
    rchk("sp", OFF_SP, 16'h00F0);
    cmd({4'h0, CMD_PUSH_ACC});
    rchk("sp", OFF_SP, 16'h00EF);
    rmem(16'h01F0, 8'h3C);
    wr(OFF_ACC, 8'h00);
    cmd({4'h0, CMD_POP_ACC});
    rchk("acc", OFF_ACC, 16'h003C);
    cmd({4'h0, CMD_PUSH_FLAGS});
    rmem(16'h01F0, 8'h04);
    wr(OFF_FLAGS, 8'h00);
    cmd({4'h0, CMD_POP_FLAGS});
    rchk("flags", OFF_FLAGS, 16'h0004);
    rchk("sp", OFF_SP, 16'h00F0);
    // Call saves the counter alone
    pc(16'h1234);
    win(16'h2345);
    cmd({4'h0, CMD_CALL});
    rpc(16'h2345);
    rchk("sp", OFF_SP, 16'h00EE);
    rmem(16'h01F0, 8'h12);
    rmem(16'h01EF, 8'h34);
    cmd({4'h0, CMD_RET_SUB});
    rpc(16'h1234);
    win(16'h0056);
    cmd({4'h0, CMD_CALL_SPC});
    rpc(16'h3F56);
    cmd({4'h0, CMD_RET_SUB});
    // Full nesting depth and back
    win(16'h2345);
    repeat (64) cmd({4'h0, CMD_CALL});
    rchk("sp", OFF_SP, 16'h0070);
    repeat (64) cmd({4'h0, CMD_RET_SUB});
    rpc(16'h1234);
    // Interrupt entry from source 2 with interrupts enabled
    wr(OFF_FLAGS, 8'h00);
    cmd(8'h28);
    rpc(16'h1E5F);
    chk("rom_addr", rom_addr, 16'h3FFB);
    chk("rom_rd", {15'h0, rom_rd}, 16'h0000);
    rchk("flags", OFF_FLAGS, 16'h0004);
    rchk("sp", OFF_SP, 16'h00ED);
    chk("ack_cnt", ack_cnt[15:0], 16'h0001);
    chk("ack_src", {13'h0, ack_src}, 16'h0002);
    rmem(16'h01F0, 8'h12);
    rmem(16'h01EF, 8'h34);
    rmem(16'h01EE, 8'h00);
    cmd({4'h0, CMD_RET_IRQ});
    rchk("flags", OFF_FLAGS, 16'h0000);
    rpc(16'h1234);
    // Disabled interrupt from source 1 is ignored
    wr(OFF_FLAGS, 8'h04);
    cmd(8'h18);
    rpc(16'h1234);
    rchk("sp", OFF_SP, 16'h00F0);
    chk("ack_cnt", ack_cnt[15:0], 16'h0001);
    tally_and_finish();
  end

endmodule : crs_core_regs_bench

`default_nettype wire
